/* mss_pkg.sv */
/*
 Constants and types for the motor start/transition supervisor.
 Assumes a 250 MHz processing clock and millisecond timer settings.
*/
package mss_pkg;
   typedef enum logic [1:0] {ST_STOP, ST_START, ST_RUN, ST_TRIP} mss_state_t;
   // transition criterion codes
   localparam logic [1:0] TRN_TIME = 2'h0;
   localparam logic [1:0] TRN_CUR = 2'h1;
   localparam logic [1:0] TRN_T_OR_I = 2'h2;
   localparam logic [1:0] TRN_T_AND_I = 2'h3;
   // start threshold as percent of full-load current
   localparam logic [31:0] START_PCT = 32'h0000001E;
   localparam logic [31:0] FULL_PCT = 32'h00000064;
   // time base
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TICK_PERIOD_PS = 1000000000;
   localparam int CYC_PER_MS = TICK_PERIOD_PS / CLK_PERIOD_PS;
   localparam int REV_DELAY_MS = 100;
   localparam int SEQ_GLITCH_MS = 500;
   localparam logic [15:0] REV_DELAY_TICKS = 16'(REV_DELAY_MS);
   localparam logic [15:0] SEQ_GLITCH_TICKS = 16'(SEQ_GLITCH_MS);
   // timer slots
   localparam int N_TMR = 6;
   localparam int T_TRN = 0;
   localparam int T_ZSS = 1;
   localparam int T_RB = 2;
   localparam int T_GL = 3;
   localparam int T_REV = 4;
   localparam int T_ABS = 5;
   localparam logic [15:0] TMR_RST = 16'h0000;
endpackage

/* mss_tmr_if.sv */
/*
 Control and status bundle of one millisecond down-counter.
 Assumes one clock domain; tick is a one-cycle pulse per millisecond.
*/
`timescale 1ns/1ns
`default_nettype none
interface mss_tmr_if;
   logic load;
   logic clear;
   logic tick;
   logic [15:0] preset;
   logic [15:0] remain;
   logic expired;
   modport ctl (output load, output clear, output tick, output preset,
                input remain, input expired);
   modport tmr (input load, input clear, input tick, input preset,
                output remain, output expired);
endinterface
`default_nettype wire

/* mss_tick.sv */
/*
 Millisecond tick generator.
 Assumes a synchronised active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module mss_tick
   import mss_pkg::*;
#(
   parameter int CYC_PER_TICK = CYC_PER_MS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // tick out
   output logic tick
);
   logic [31:0] cnt_r, cnt_nxt;
   logic tick_r, tick_nxt;

   always_comb begin
      tick_nxt = 1'b0;
      cnt_nxt = cnt_r + 32'h00000001;
      if (cnt_r >= 32'(CYC_PER_TICK - 1)) begin
         cnt_nxt = 32'h00000000;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 32'h00000000;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule
`default_nettype wire

/* mss_timer.sv */
/*
 Loadable millisecond down-counter; expired while armed and at zero.
 Assumes clear wins over load in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module mss_timer
   import mss_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control bundle
   mss_tmr_if.tmr t
);
   logic [15:0] remain_r, remain_nxt;
   logic armed_r, armed_nxt;

   always_comb begin
      remain_nxt = remain_r;
      armed_nxt = armed_r;
      if (t.clear) begin
         remain_nxt = TMR_RST;
         armed_nxt = 1'b0;
      end else if (t.load) begin
         remain_nxt = t.preset;
         armed_nxt = 1'b1;
      end else if (t.tick && armed_r && remain_r != TMR_RST) begin
         remain_nxt = remain_r - 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remain_r <= TMR_RST;
         armed_r <= 1'b0;
      end else begin
         remain_r <= remain_nxt;
         armed_r <= armed_nxt;
      end
   end

   assign t.remain = remain_r;
   assign t.expired = armed_r && remain_r == TMR_RST;
endmodule
`default_nettype wire

/* mss_supervisor.sv */
/*
 Motor start/transition supervisor: operation state, transition timing,
 incomplete-sequence, zero-speed, rotation and backspin supervision.
 Assumes current magnitudes, settings and digital inputs are synchronous
 to clk; all timer settings are in milliseconds.
*/
`timescale 1ns/1ns
`default_nettype none
module mss_supervisor
   import mss_pkg::*;
#(
   parameter int CYC_PER_TICK = CYC_PER_MS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // phase current magnitudes
   input wire logic [15:0] cur_l1,
   input wire logic [15:0] cur_l2,
   input wire logic [15:0] cur_l3,
   // current and timing settings
   input wire logic [15:0] full_load_current,
   input wire logic [15:0] transition_current_level,
   input wire logic [15:0] stop_current_threshold,
   input wire logic [15:0] transition_timer,
   input wire logic [1:0] transition_rule_select,
   input wire logic [15:0] locked_rotor_time,
   input wire logic [15:0] report_back_time,
   input wire logic [15:0] backspin_delay,
   // function enables and modes
   input wire logic seq_check_en,
   input wire logic seq_supervision_mode,
   input wire logic speed_switch_check,
   input wire logic backspin_en,
   input wire logic reversing_allowed,
   input wire logic phase_sequence_cfg,
   // measured rotation and symmetrical components
   input wire logic meas_rotation,
   input wire logic [15:0] pos_seq_in,
   input wire logic [15:0] neg_seq_in,
   // digital inputs
   input wire logic report_back_in,
   input wire logic speed_switch_in,
   input wire logic prot_trip_in,
   input wire logic start_limit_block,
   // state and transition status
   output logic [1:0] op_state,
   output logic start_declared,
   output logic trn_current_seen,
   output logic trn_by_time,
   output logic trn_by_current,
   output logic trip_contact_closed,
   // trip indications
   output logic failed_transition_trip,
   output logic seq_start_to_run_failure,
   output logic seq_stop_to_start_failure,
   output logic speed_switch_trip,
   output logic reverse_rotation_trip,
   output logic module_trip,
   output logic breaker_trip_command,
   // rotation and components
   output logic rotating_forward,
   output logic rotating_backward,
   output logic [15:0] pos_seq_out,
   output logic [15:0] neg_seq_out,
   // start blocking
   output logic start_blocked,
   output logic [15:0] backspin_remaining
);

   function automatic logic all_below(input logic [15:0] a, input logic [15:0] b,
                                      input logic [15:0] c, input logic [15:0] thr);
      all_below = a < thr && b < thr && c < thr;
   endfunction

   function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
      logic [15:0] m;
      m = a > b ? a : b;
      max3 = m > c ? m : c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_s1_r, rst_s2_r;
   logic rst_n;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   assign rst_n = rst_s2_r;

   ////////////////////////////////////////////////////////////////////////////
   // time base and timers
   logic tick;
   // per-slot strobes; interface array elements need constant indices
   logic [N_TMR-1:0] tmr_load, tmr_clear;
   mss_tmr_if t [N_TMR] ();

   mss_tick #(.CYC_PER_TICK(CYC_PER_TICK)) u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   genvar g;
   generate
      for (g = 0; g < N_TMR; g++) begin : g_tmr
         assign t[g].tick = tick;
         assign t[g].load = tmr_load[g];
         assign t[g].clear = tmr_clear[g];
         mss_timer u_tmr (
            .clk(clk),
            .rst_n(rst_n),
            .t(t[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // current comparisons
   logic [15:0] cur_max;
   logic over_start, under_trn, under_stop, forward_now;

   assign cur_max = max3(cur_l1, cur_l2, cur_l3);
   // widened products so a full-scale setting cannot wrap
   assign over_start = {16'h0000, cur_max} * FULL_PCT >
                       {16'h0000, full_load_current} * START_PCT;
   assign under_trn = cur_max < transition_current_level;
   assign under_stop = all_below(cur_l1, cur_l2, cur_l3,
                                 stop_current_threshold);
   assign forward_now = meas_rotation == phase_sequence_cfg;

   ////////////////////////////////////////////////////////////////////////////
   // state and indications
   mss_state_t state_r, state_nxt;
   logic start_r, start_nxt;
   logic seen_r, seen_nxt;
   logic by_t_r, by_t_nxt;
   logic by_i_r, by_i_nxt;
   logic ftt_r, ftt_nxt;
   logic s2r_r, s2r_nxt;
   logic s2s_r, s2s_nxt;
   logic zss_r, zss_nxt;
   logic rev_r, rev_nxt;
   logic mtrip_r, mtrip_nxt;
   logic cmd_r, cmd_nxt;
   logic contact_r, contact_nxt;
   logic fwd_r, fwd_nxt;
   logic bwd_r, bwd_nxt;
   logic [15:0] pos_r, pos_nxt;
   logic [15:0] neg_r, neg_nxt;
   logic blk_r, blk_nxt;
   logic [15:0] abs_r, abs_nxt;
   logic rb_exp_d_r, rb_exp_d_nxt;
   logic rb_in_d_r, rb_in_d_nxt;

   logic active, trn_exp, trn_run, trn_fail, seq_fail, zss_fail, rev_fail;

   always_comb begin
      state_nxt = state_r;
      start_nxt = 1'b0;
      seen_nxt = seen_r;
      by_t_nxt = by_t_r;
      by_i_nxt = by_i_r;
      ftt_nxt = ftt_r;
      s2r_nxt = s2r_r;
      s2s_nxt = s2s_r;
      zss_nxt = zss_r;
      rev_nxt = rev_r;
      tmr_load = {N_TMR{1'b0}};
      tmr_clear = {N_TMR{1'b0}};
      t[T_TRN].preset = transition_timer;
      t[T_ZSS].preset = {1'b0, locked_rotor_time[15:1]};
      t[T_RB].preset = report_back_time;
      t[T_GL].preset = SEQ_GLITCH_TICKS;
      t[T_REV].preset = REV_DELAY_TICKS;
      t[T_ABS].preset = backspin_delay;

      active = state_r == ST_START || state_r == ST_RUN;
      trn_exp = t[T_TRN].expired;
      trn_run = 1'b0;
      trn_fail = 1'b0;
      unique case (transition_rule_select)
         TRN_TIME: trn_run = trn_exp;
         TRN_CUR: begin
            trn_run = under_trn;
            trn_fail = trn_exp && !under_trn;
         end
         TRN_T_OR_I: trn_run = trn_exp || under_trn;
         TRN_T_AND_I: begin
            // current must have dropped by the time the timer ends
            trn_run = trn_exp && (seen_r || under_trn);
            trn_fail = trn_exp && !(seen_r || under_trn);
         end
      endcase

      // report-back input: checked once at expiry, then glitch-filtered
      rb_exp_d_nxt = t[T_RB].expired;
      rb_in_d_nxt = report_back_in;
      if (!active || !seq_check_en || report_back_in || !t[T_RB].expired) begin
         tmr_clear[T_GL] = 1'b1;
      end else if (rb_in_d_r || !rb_exp_d_r) begin
         tmr_load[T_GL] = 1'b1;
      end
      seq_fail = active && seq_check_en &&
                 ((t[T_RB].expired && !rb_exp_d_r && !report_back_in) ||
                  t[T_GL].expired);
      zss_fail = active && speed_switch_check && t[T_ZSS].expired &&
                 speed_switch_in;
      rev_fail = active && !reversing_allowed && t[T_REV].expired &&
                 !forward_now;

      unique case (state_r)
         ST_STOP: begin
            if (over_start) begin
               state_nxt = ST_START;
               start_nxt = 1'b1;
               seen_nxt = 1'b0;
               by_t_nxt = 1'b0;
               by_i_nxt = 1'b0;
               ftt_nxt = 1'b0;
               s2r_nxt = 1'b0;
               s2s_nxt = 1'b0;
               zss_nxt = 1'b0;
               rev_nxt = 1'b0;
               tmr_load[T_TRN] = 1'b1;
               tmr_load[T_ZSS] = 1'b1;
               tmr_load[T_RB] = 1'b1;
               tmr_load[T_REV] = 1'b1;
               tmr_clear[T_ABS] = 1'b1;
               if (speed_switch_check && !speed_switch_in) begin
                  state_nxt = ST_TRIP;
                  zss_nxt = 1'b1;
               end
            end
         end
         ST_START: begin
            if (under_trn) begin
               seen_nxt = 1'b1;
            end
            if (prot_trip_in || seq_fail || zss_fail || rev_fail || trn_fail) begin
               state_nxt = ST_TRIP;
            end else if (trn_run) begin
               state_nxt = ST_RUN;
               tmr_clear[T_TRN] = 1'b1;
               by_t_nxt = trn_exp && transition_rule_select != TRN_CUR;
               by_i_nxt = under_trn || (seen_r && trn_exp &&
                          transition_rule_select == TRN_T_AND_I);
               if (transition_rule_select == TRN_TIME) begin
                  by_i_nxt = 1'b0;
               end
            end
            ftt_nxt = ftt_r || (trn_fail && !prot_trip_in && !seq_fail &&
                      !zss_fail && !rev_fail);
         end
         ST_RUN: begin
            if (prot_trip_in || seq_fail || zss_fail || rev_fail) begin
               state_nxt = ST_TRIP;
            end else if (under_stop) begin
               state_nxt = ST_STOP;
               by_t_nxt = 1'b0;
               by_i_nxt = 1'b0;
            end
         end
         ST_TRIP: begin
            if (under_stop) begin
               state_nxt = ST_STOP;
            end
         end
      endcase

      if (active && seq_fail) begin
         s2r_nxt = !seq_supervision_mode;
         s2s_nxt = seq_supervision_mode;
      end
      if (zss_fail) begin
         zss_nxt = 1'b1;
      end
      if (rev_fail) begin
         rev_nxt = 1'b1;
      end

      // leaving run or trip: drop supervision timers, arm backspin delay
      if (state_nxt == ST_STOP && state_r != ST_STOP) begin
         for (int i = 0; i < T_ABS; i++) begin
            tmr_clear[i] = 1'b1;
         end
         if (backspin_en) begin
            tmr_load[T_ABS] = 1'b1;
         end
      end

      mtrip_nxt = state_nxt == ST_TRIP;
      cmd_nxt = state_nxt == ST_TRIP;
      contact_nxt = state_nxt != ST_TRIP;
      fwd_nxt = forward_now;
      bwd_nxt = !forward_now;
      // swapped components keep negative-sequence elements quiet
      pos_nxt = (reversing_allowed && !forward_now) ? neg_seq_in : pos_seq_in;
      neg_nxt = (reversing_allowed && !forward_now) ? pos_seq_in : neg_seq_in;
      abs_nxt = t[T_ABS].remain;
      // start limits are only indicated; the contactor scheme enforces them
      blk_nxt = state_nxt == ST_STOP && (start_limit_block ||
                (backspin_en && t[T_ABS].remain != TMR_RST));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_STOP;
         start_r <= 1'b0;
         seen_r <= 1'b0;
         by_t_r <= 1'b0;
         by_i_r <= 1'b0;
         ftt_r <= 1'b0;
         s2r_r <= 1'b0;
         s2s_r <= 1'b0;
         zss_r <= 1'b0;
         rev_r <= 1'b0;
         mtrip_r <= 1'b0;
         cmd_r <= 1'b0;
         contact_r <= 1'b1;
         fwd_r <= 1'b0;
         bwd_r <= 1'b0;
         pos_r <= 16'h0000;
         neg_r <= 16'h0000;
         blk_r <= 1'b0;
         abs_r <= 16'h0000;
         rb_exp_d_r <= 1'b0;
         rb_in_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         start_r <= start_nxt;
         seen_r <= seen_nxt;
         by_t_r <= by_t_nxt;
         by_i_r <= by_i_nxt;
         ftt_r <= ftt_nxt;
         s2r_r <= s2r_nxt;
         s2s_r <= s2s_nxt;
         zss_r <= zss_nxt;
         rev_r <= rev_nxt;
         mtrip_r <= mtrip_nxt;
         cmd_r <= cmd_nxt;
         contact_r <= contact_nxt;
         fwd_r <= fwd_nxt;
         bwd_r <= bwd_nxt;
         pos_r <= pos_nxt;
         neg_r <= neg_nxt;
         blk_r <= blk_nxt;
         abs_r <= abs_nxt;
         rb_exp_d_r <= rb_exp_d_nxt;
         rb_in_d_r <= rb_in_d_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign op_state = state_r;
   assign start_declared = start_r;
   assign trn_current_seen = seen_r;
   assign trn_by_time = by_t_r;
   assign trn_by_current = by_i_r;
   assign trip_contact_closed = contact_r;
   assign failed_transition_trip = ftt_r;
   assign seq_start_to_run_failure = s2r_r;
   assign seq_stop_to_start_failure = s2s_r;
   assign speed_switch_trip = zss_r;
   assign reverse_rotation_trip = rev_r;
   assign module_trip = mtrip_r;
   assign breaker_trip_command = cmd_r;
   assign rotating_forward = fwd_r;
   assign rotating_backward = bwd_r;
   assign pos_seq_out = pos_r;
   assign neg_seq_out = neg_r;
   assign start_blocked = blk_r;
   assign backspin_remaining = abs_r;
endmodule
`default_nettype wire

/* mss_supervisor_assertions.sv */
/*
 Concurrent checks on the supervisor's ports.
 Assumes a single clk domain and rstn as the only reset.
*/
`timescale 1ns/1ns
`default_nettype none
module mss_supervisor_assertions
   import mss_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // inputs watched
   input wire logic [15:0] cur_l1,
   input wire logic [15:0] cur_l2,
   input wire logic [15:0] cur_l3,
   input wire logic [15:0] full_load_current,
   input wire logic [15:0] stop_current_threshold,
   input wire logic [1:0] transition_rule_select,
   input wire logic meas_rotation,
   input wire logic phase_sequence_cfg,
   // outputs watched
   input wire logic [1:0] op_state,
   input wire logic start_declared,
   input wire logic trn_by_time,
   input wire logic trn_by_current,
   input wire logic trip_contact_closed,
   input wire logic failed_transition_trip,
   input wire logic module_trip,
   input wire logic breaker_trip_command,
   input wire logic rotating_forward,
   input wire logic rotating_backward
);
   logic [1:0] live_r;
   logic [1:0] live_nxt;
   logic [15:0] cmax;
   logic above_start;
   logic all_low;
   // inputs are only acted on from the third edge after release
   always_comb begin
      live_nxt = (live_r == 2'h3) ? live_r : live_r + 2'h1;
      cmax = (cur_l1 > cur_l2) ? cur_l1 : cur_l2;
      if (cur_l3 > cmax) begin
         cmax = cur_l3;
      end
      above_start = ({16'h0000, cmax} * FULL_PCT) > ({16'h0000, full_load_current} * START_PCT);
      all_low = cur_l1 < stop_current_threshold && cur_l2 < stop_current_threshold &&
                cur_l3 < stop_current_threshold;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         live_r <= 2'h0;
      end else begin
         live_r <= live_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_stop_high;
      live_r == 2'h3 && op_state == ST_STOP && above_start;
   endsequence
   sequence s_run_entry;
      op_state == ST_START ##1 op_state == ST_RUN;
   endsequence
   a_start_detect: assert property (s_stop_high |=> start_declared && op_state != ST_STOP)
      else $error("start not declared");
   a_start_pulse: assert property (
      start_declared |-> $past(op_state) == ST_STOP ##1 !start_declared)
      else $error("start pulse wrong");
   a_run_flags: assert property (s_run_entry |-> trn_by_time || trn_by_current)
      else $error("run without transition flag");
   a_time_only: assert property (
      op_state == ST_RUN && transition_rule_select == TRN_TIME |-> trn_by_time && !trn_by_current)
      else $error("time rule flags wrong");
   a_and_both: assert property (
      op_state == ST_RUN && transition_rule_select == TRN_T_AND_I |-> trn_by_time && trn_by_current)
      else $error("and rule flags wrong");
   a_fail_trip: assert property (
      $rose(failed_transition_trip) |-> op_state == ST_TRIP && $past(op_state) == ST_START)
      else $error("transition trip out of start");
   a_contact_state: assert property (trip_contact_closed == (op_state != ST_TRIP))
      else $error("trip contact wrong");
   a_trip_cmd: assert property (
      module_trip == (op_state == ST_TRIP) && breaker_trip_command == module_trip)
      else $error("trip command wrong");
   a_stop_decl: assert property (
      live_r == 2'h3 && op_state inside {ST_RUN, ST_TRIP} && all_low |=> op_state == ST_STOP)
      else $error("stop not declared");
   a_rot_flags: assert property (
      live_r == 2'h3 && $past(live_r) == 2'h3 |->
      rotating_forward == $past(meas_rotation == phase_sequence_cfg) &&
      rotating_backward == !rotating_forward)
      else $error("rotation flags wrong");
endmodule
bind mss_supervisor mss_supervisor_assertions u_chk (.*);
`default_nettype wire

/* mss_partner.sv */
/*
 Far side: process report-back contact and zero-speed switch.
 Assumes op_state from the supervisor; modes come from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module mss_partner
   import mss_pkg::*;
(
   // clock and state
   input wire logic clk,
   input wire logic [1:0] op_state,
   // behaviour select: 0 normal switch, 1 stuck closed, 2 open
   input wire logic [1:0] ss_mode,
   input wire logic rb_ok,
   input wire logic rb_drop,
   // contacts
   output logic speed_switch_in,
   output logic report_back_in
);
   logic [15:0] run_cnt_r;
   always_ff @(posedge clk) begin
      run_cnt_r <= (op_state == ST_STOP) ? 16'h0000 : run_cnt_r + 16'h0001;
      // closed at rest, opens once the rotor picks up
      speed_switch_in <= (ss_mode == 2'h1) || (ss_mode == 2'h0 && run_cnt_r < 16'h0008);
      // reports back soon after start, holds unless told to drop
      report_back_in <= rb_ok && !rb_drop && run_cnt_r >= 16'h0008;
   end
endmodule
`default_nettype wire

/* mss_supervisor_tb.sv */
/*
 Self-checking bench for the supervisor with a far-side contact model.
 Assumes a 4-cycle millisecond tick so timers stay short.
*/
`timescale 1ns/1ns
`default_nettype none
module mss_supervisor_tb
   import mss_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] cur_l1, cur_l2, cur_l3, full_load_current, transition_current_level;
   logic [15:0] stop_current_threshold, transition_timer, locked_rotor_time, report_back_time;
   logic [15:0] backspin_delay, pos_seq_in, neg_seq_in, pos_seq_out, neg_seq_out, backspin_remaining;
   logic [1:0] transition_rule_select, op_state, ss_mode;
   logic seq_check_en, seq_supervision_mode, speed_switch_check, backspin_en, reversing_allowed;
   logic phase_sequence_cfg, meas_rotation, report_back_in, speed_switch_in, prot_trip_in;
   logic start_limit_block, start_declared, trn_current_seen, trn_by_time, trn_by_current;
   logic trip_contact_closed, failed_transition_trip, seq_start_to_run_failure, start_blocked;
   logic seq_stop_to_start_failure, speed_switch_trip, reverse_rotation_trip, module_trip;
   logic breaker_trip_command, rotating_forward, rotating_backward, rb_ok, rb_drop;
   int fail_count = 0;
   int samples_checked = 0;
   int r, d, m;
   always #2 clk = ~clk;
   mss_supervisor #(.CYC_PER_TICK(4)) DUT (.*);
   mss_partner u_far (.*);
   ////////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // third phase runs lighter to exercise the maximum pick
   task cur(input logic [15:0] v);
      cur_l1 = v;
      cur_l2 = v;
      cur_l3 = v >> 1;
   endtask
   task go(input logic [1:0] rule, input logic [15:0] tt, input logic [15:0] amps);
      transition_rule_select = rule;
      transition_timer = tt;
      cur(amps);
      for (int i = 0; i < 4 && start_declared !== 1'b1; i++) cyc(1);
      chk(start_declared, 1'b1);
   endtask
   task halt;
      cur(16'h0000);
      cyc(6);
      chk(op_state, ST_STOP);
   endtask
   function mss_state_t exp_state(int r, int d);
      return ((r == 1 || r == 3) && d == 0) ? ST_TRIP : ST_RUN;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cur(16'h0000);
      full_load_current = 16'h03E8;
      transition_current_level = 16'h00FA;
      stop_current_threshold = 16'h0032;
      {transition_timer, locked_rotor_time, report_back_time} = {16'h000A, 16'h0014, 16'h000A};
      {backspin_delay, pos_seq_in, neg_seq_in} = {16'h0005, 16'h0000, 16'h0000};
      transition_rule_select = TRN_TIME;
      {seq_check_en, seq_supervision_mode, speed_switch_check, backspin_en} = 4'h0;
      {reversing_allowed, phase_sequence_cfg, meas_rotation, prot_trip_in, start_limit_block} = 5'h1C;
      {ss_mode, rb_ok, rb_drop} = 4'h0;
      void'($urandom(53005));
      cyc(8);
      rstn = 1'b1;
      cyc(4);
      chk(op_state, ST_STOP);
      chk(trip_contact_closed, 1'b1);
      cur(16'h012C);
      cyc(6);
      chk(op_state, ST_STOP);
      $display("reset and threshold test done");
      for (r = 0; r < 4; r++) for (d = 0; d < 2; d++) begin
         go(r[1:0], 16'h0008 + 16'($urandom % 8),
            (r + d == 0) ? 16'h012D : 16'h0258 + 16'($urandom % 900));
         chk(op_state, ST_START);
         cyc(4);
         if (d == 1) cur(16'h0064 + 16'($urandom % 140));
         cyc(3);
         chk(trn_current_seen, d == 1);
         cyc(4 * transition_timer + 12);
         chk(op_state, exp_state(r, d));
         chk(trn_by_time, exp_state(r, d) == ST_RUN && (r == 0 || r == 3 || (r == 2 && d == 0)));
         chk(trn_by_current, d == 1 && r != 0);
         chk(failed_transition_trip, exp_state(r, d) == ST_TRIP);
         chk(trip_contact_closed, exp_state(r, d) == ST_RUN);
         halt();
      end
      $display("transition test done");
      go(TRN_TIME, 16'h0004, 16'h0320);
      cyc(30);
      prot_trip_in = 1'b1;
      cyc(3);
      chk(op_state, ST_TRIP);
      prot_trip_in = 1'b0;
      halt();
      speed_switch_check = 1'b1;
      for (m = 0; m < 3; m++) begin
         ss_mode = m[1:0];
         // let the contact model settle before the start edge
         cyc(2);
         go(TRN_CUR, 16'h00C8, 16'h0320);
         cyc(2);
         chk(op_state == ST_TRIP, m == 2);
         cyc(58);
         chk(speed_switch_trip, m != 0);
         halt();
      end
      {speed_switch_check, ss_mode} = 3'h0;
      $display("trip and speed switch test done");
      for (m = 0; m < 2; m++) begin
         {reversing_allowed, meas_rotation} = {m[0], 1'b0};
         {pos_seq_in, neg_seq_in} = {16'($urandom), 16'($urandom)};
         go(TRN_CUR, 16'h00C8, 16'h0320);
         cyc(3);
         chk({rotating_forward, rotating_backward}, 2'h1);
         chk(pos_seq_out, m ? neg_seq_in : pos_seq_in);
         chk(neg_seq_out, m ? pos_seq_in : neg_seq_in);
         cyc(340);
         chk(op_state, ST_START);
         cyc(80);
         chk({reverse_rotation_trip, breaker_trip_command}, m ? 2'h0 : 2'h3);
         halt();
      end
      {reversing_allowed, meas_rotation} = 2'h3;
      $display("rotation test done");
      seq_check_en = 1'b1;
      for (m = 0; m < 2; m++) begin
         seq_supervision_mode = m[0];
         go(TRN_CUR, 16'h00C8, 16'h0320);
         cyc(60);
         chk(op_state, ST_TRIP);
         chk({seq_start_to_run_failure, seq_stop_to_start_failure}, m ? 2'h1 : 2'h2);
         halt();
      end
      rb_ok = 1'b1;
      go(TRN_TIME, 16'h0005, 16'h0320);
      cyc(60);
      chk(op_state, ST_RUN);
      rb_drop = 1'b1;
      cyc(1900);
      chk(op_state, ST_RUN);
      cyc(150);
      chk(op_state, ST_TRIP);
      {seq_check_en, rb_ok, rb_drop} = 3'h0;
      halt();
      $display("sequence test done");
      backspin_en = 1'b1;
      go(TRN_TIME, 16'h0004, 16'h0320);
      cyc(30);
      halt();
      chk(start_blocked, 1'b1);
      chk(backspin_remaining != 16'h0000, 1'b1);
      cyc(40);
      chk(start_blocked, 1'b0);
      start_limit_block = 1'b1;
      cyc(3);
      chk(start_blocked, 1'b1);
      start_limit_block = 1'b0;
      $display("backspin test done");
      tally_and_finish();
   end
   // whole run is some 4000 cycles; allow about five times that
   initial begin
      #80000;
      fail_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
